// [logic/fps_pkg.sv]
// constants and types shared by the four-channel power sequencer
package fps_pkg;
	localparam int unsigned NUM_CHAN         = 4;
	localparam int unsigned TMR_W            = 20;
	localparam int unsigned CLK_PERIOD_NS    = 5;
	// timer lengths in ns; the reset timeout length is a free choice
	localparam int unsigned SEQ_DELAY_NS     = 40000;
	localparam int unsigned PG_WINDOW_NS     = 5000;
	localparam int unsigned RESET_TIMEOUT_NS = 200000;
	localparam int unsigned FAULT_PULSE_NS   = 80000;
	// least times, rounded up to whole cycles
	localparam int unsigned SEQ_DELAY_CYC    = (SEQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PG_WINDOW_CYC    = (PG_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RESET_TMO_CYC    = (RESET_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FAULT_PULSE_CYC  = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// reset values
	localparam logic [3:0]  CHAN_RST         = 4'h0;
	localparam logic [7:0]  SYNC_RST         = 8'hc2;  // idle pin levels, so no false edge

	typedef enum logic [6:0] {
		FPS_INIT     = 7'h01,
		FPS_IDLE     = 7'h02,
		FPS_ON_DLY   = 7'h04,
		FPS_ON_PGT   = 7'h08,
		FPS_UP       = 7'h10,
		FPS_OFF_DLY  = 7'h20,
		FPS_OFF_WAIT = 7'h40
	} fps_state_type;
endpackage

// [logic/fps_sequencer.sv]
// four-channel power sequencer and supervisor core
`timescale 1ns/100ps
`default_nettype none

module fps_sequencer
	import fps_pkg::*;
#(
	parameter int unsigned SEQ_DELAY_CYCLES   = SEQ_DELAY_CYC,  // minimum delay default
	parameter int unsigned PG_WINDOW_CYCLES   = PG_WINDOW_CYC,
	parameter int unsigned RESET_TMO_CYCLES   = RESET_TMO_CYC,
	parameter int unsigned FAULT_PULSE_CYCLES = FAULT_PULSE_CYC
) (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst,
	input  wire logic       i_power_on_cmp,
	input  wire logic       i_power_off_cmp,
	input  wire logic [3:0] i_chan_feedback,
	input  wire logic       i_undervoltage_sense,
	input  wire logic       i_fault_n_in,
	output logic      [3:0] o_chan_enable,
	output logic      [3:0] o_offset_current_en,
	output logic            o_seq_done,
	output logic            o_power_good_out,
	output logic            o_fault_n_out,
	output logic            o_fault_oe
);

	localparam logic [TMR_W-1:0] DLY_LOAD = TMR_W'(SEQ_DELAY_CYCLES - 1);
	localparam logic [TMR_W-1:0] PGT_LOAD = TMR_W'(PG_WINDOW_CYCLES - 1);
	localparam logic [TMR_W-1:0] RTO_LOAD = TMR_W'(RESET_TMO_CYCLES - 1);
	localparam logic [TMR_W-1:0] FLT_LOAD = TMR_W'(FAULT_PULSE_CYCLES);

	// lowest active channel at or above lo, msb flags found
	function automatic logic [2:0] pick_up(input logic [3:0] act, input logic [2:0] lo);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 3; i >= 0; i--) begin
			if (act[i] && (3'(i) >= lo)) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	// highest active channel below lim, msb flags found
	function automatic logic [2:0] pick_dn(input logic [3:0] act, input logic [2:0] lim);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (act[i] && (3'(i) < lim)) begin
				r = {1'b1, 2'(i)};
			end
		end
		return r;
	endfunction

	fps_state_type    state_reg;
	logic [1:0]       ch_reg;
	logic [TMR_W-1:0] tmr_reg;
	logic [3:0]       en_reg;
	logic [3:0]       offs_reg;
	logic [3:0]       good_reg;
	logic [3:0]       skip_reg;
	logic             done_reg;
	logic             pok_reg;
	logic [TMR_W-1:0] fp_cnt_reg;
	logic             uv_hold_reg;
	logic             fault_oe_reg;
	logic             oe_d1_reg;
	logic             oe_d2_reg;
	logic [7:0]       sync1_reg;
	logic [7:0]       sync2_reg;
	logic [7:0]       prev_reg;
	logic             on_s;
	logic             off_s;
	logic [3:0]       fb_s;
	logic             uv_ok;
	logic             fault_n_s;
	logic             on_rise;
	logic             on_fall;
	logic             off_fall;
	logic             seq_on;
	logic             pgt_fault;
	logic             on_fault;
	logic             mon_fault;
	logic             uv_fault;
	logic             ext_fault;
	logic             self_fault;
	logic             any_fault;
	logic [2:0]       nxt_up;
	logic [2:0]       nxt_dn;
	logic [2:0]       first_up;
	logic [2:0]       first_dn;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			sync1_reg <= SYNC_RST;
			sync2_reg <= SYNC_RST;
			prev_reg  <= SYNC_RST;
		end else begin
			sync1_reg <= {i_fault_n_in, i_undervoltage_sense, i_chan_feedback,
				i_power_off_cmp, i_power_on_cmp};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// synchronized levels and edges
	assign on_s      = sync2_reg[0];
	assign off_s     = sync2_reg[1];
	assign fb_s      = sync2_reg[5:2];
	assign uv_ok     = sync2_reg[6];
	assign fault_n_s = sync2_reg[7];
	assign on_rise   = on_s & ~prev_reg[0];
	assign on_fall   = ~on_s & prev_reg[0];
	assign off_fall  = ~off_s & prev_reg[1];

	// next channel lookups over the active set
	assign nxt_up   = pick_up(~skip_reg, {1'b0, ch_reg} + 3'h1);
	assign nxt_dn   = pick_dn(~skip_reg, {1'b0, ch_reg});
	assign first_up = pick_up(~skip_reg, 3'h0);
	assign first_dn = pick_dn(~skip_reg, 3'h4);

	// fault causes
	assign seq_on    = (state_reg == FPS_ON_DLY) || (state_reg == FPS_ON_PGT);
	assign pgt_fault = (state_reg == FPS_ON_PGT) && (tmr_reg == '0) && !fb_s[ch_reg];
	assign on_fault  = seq_on && (on_rise || on_fall);
	assign mon_fault = (seq_on || (state_reg == FPS_UP)) && |(good_reg & ~fb_s);
	assign uv_fault  = (state_reg == FPS_UP) && !uv_ok;
	// low line not of our own making
	assign ext_fault = !fault_n_s && !fault_oe_reg && !oe_d1_reg && !oe_d2_reg;
	assign self_fault = pgt_fault || on_fault || mon_fault;
	assign any_fault  = self_fault || uv_fault || ext_fault;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			fp_cnt_reg <= '0;
		end else if (self_fault) begin
			fp_cnt_reg <= FLT_LOAD;
		end else if (fp_cnt_reg != '0) begin
			fp_cnt_reg <= fp_cnt_reg - TMR_W'(1);
		end
	end

	// undervoltage hold, set wins over clear
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			uv_hold_reg <= 1'b0;
		end else if (uv_fault) begin
			uv_hold_reg <= 1'b1;
		end else if (uv_ok) begin
			uv_hold_reg <= 1'b0;
		end
	end

	// fault line drive, released in reset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			fault_oe_reg <= 1'b0;
			oe_d1_reg    <= 1'b0;
			oe_d2_reg    <= 1'b0;
		end else begin
			fault_oe_reg <= self_fault || uv_fault || (fp_cnt_reg > TMR_W'(1))
				|| (uv_hold_reg && !uv_ok);
			oe_d1_reg    <= fault_oe_reg;
			oe_d2_reg    <= oe_d1_reg;
		end
	end

	// sequencing state machine with shared timer
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state_reg <= FPS_INIT;
			ch_reg    <= 2'h0;
			tmr_reg   <= '0;
			en_reg    <= CHAN_RST;
			offs_reg  <= CHAN_RST;
			good_reg  <= CHAN_RST;
			skip_reg  <= CHAN_RST;
			done_reg  <= 1'b0;
		end else if (any_fault) begin
			state_reg <= FPS_INIT;
			tmr_reg   <= '0;
			en_reg    <= CHAN_RST;
			offs_reg  <= CHAN_RST;
			good_reg  <= CHAN_RST;
			done_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				FPS_INIT: begin
					// wait for a quiet fault line before sampling
					if (!fault_oe_reg && !oe_d2_reg && fault_n_s && !uv_hold_reg) begin
						// high feedback marks a skipped channel
						skip_reg <= fb_s;
						if (&fb_s) begin
							state_reg <= FPS_UP;
							done_reg  <= 1'b1;
							tmr_reg   <= '0;
						end else begin
							state_reg <= FPS_IDLE;
						end
					end
				end
				FPS_IDLE: begin
					if (on_rise) begin
						ch_reg    <= first_up[1:0];
						tmr_reg   <= DLY_LOAD;
						state_reg <= FPS_ON_DLY;
					end
				end
				FPS_ON_DLY: begin
					if (tmr_reg != '0) begin
						tmr_reg <= tmr_reg - TMR_W'(1);
					end else begin
						en_reg[ch_reg] <= 1'b1;
						tmr_reg        <= PGT_LOAD;
						state_reg      <= FPS_ON_PGT;
					end
				end
				FPS_ON_PGT: begin
					if (fb_s[ch_reg]) begin
						good_reg[ch_reg] <= 1'b1;
						if (nxt_up[2]) begin
							ch_reg    <= nxt_up[1:0];
							tmr_reg   <= DLY_LOAD;
							state_reg <= FPS_ON_DLY;
						end else begin
							done_reg  <= 1'b1;
							tmr_reg   <= RTO_LOAD;
							state_reg <= FPS_UP;
						end
					end else if (tmr_reg != '0) begin
						tmr_reg <= tmr_reg - TMR_W'(1);
					end
				end
				FPS_UP: begin
					if (off_fall) begin
						good_reg <= CHAN_RST;
						if (first_dn[2]) begin
							ch_reg    <= first_dn[1:0];
							tmr_reg   <= DLY_LOAD;
							state_reg <= FPS_OFF_DLY;
						end else begin
							done_reg  <= 1'b0;
							state_reg <= FPS_IDLE;
						end
					end else if (tmr_reg != '0) begin
						tmr_reg <= tmr_reg - TMR_W'(1);
					end
				end
				FPS_OFF_DLY: begin
					if (tmr_reg != '0) begin
						tmr_reg <= tmr_reg - TMR_W'(1);
					end else begin
						en_reg[ch_reg]   <= 1'b0;
						offs_reg[ch_reg] <= 1'b1;
						state_reg        <= FPS_OFF_WAIT;
					end
				end
				FPS_OFF_WAIT: begin
					if (!fb_s[ch_reg]) begin
						offs_reg[ch_reg] <= 1'b0;
						if (nxt_dn[2]) begin
							ch_reg    <= nxt_dn[1:0];
							tmr_reg   <= DLY_LOAD;
							state_reg <= FPS_OFF_DLY;
						end else begin
							done_reg  <= 1'b0;
							state_reg <= FPS_IDLE;
						end
					end
				end
			endcase
		end
	end

	// power-OK once timeout ran out in the up state
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			pok_reg <= 1'b0;
		end else begin
			pok_reg <= (state_reg == FPS_UP) && done_reg && (tmr_reg == '0)
				&& !any_fault && !off_fall;
		end
	end

	// outputs
	assign o_chan_enable       = en_reg;
	assign o_offset_current_en = offs_reg;
	assign o_seq_done          = done_reg;
	assign o_power_good_out    = pok_reg;
	assign o_fault_n_out       = 1'b0;  // open drain: only ever pulls low
	assign o_fault_oe          = fault_oe_reg;

endmodule // fps_sequencer

`default_nettype wire

// [bench/fps_regulators.sv]
// model of the four regulators and their feedback dividers
`timescale 1ns/100ps
`default_nettype none
module fps_regulators (
	input  wire logic       i_sys_clk,
	input  wire logic [3:0] i_chan_enable,
	input  wire logic [3:0] i_offset_current_en,
	input  wire logic [3:0] i_skip,
	input  wire logic [3:0] i_dead,
	input  wire logic [2:0] i_lag,
	output logic      [3:0] o_chan_feedback
);
	logic [3:0] out_reg = 4'h0;
	logic [2:0] cnt_reg [4] = '{default: 3'h0};
	// offset current speeds decay
	// a supply follows its enable after a lag, slower to fall unaided
	always_ff @(posedge i_sys_clk) begin
		for (int c = 0; c < 4; c++) begin
			if (i_chan_enable[c] == out_reg[c]) begin
				cnt_reg[c] <= 3'h0;
			end else if (cnt_reg[c] >= i_lag + ((i_offset_current_en[c] | i_chan_enable[c]) ? 3'h0 : 3'h2)) begin
				out_reg[c] <= i_chan_enable[c];
			end else begin
				cnt_reg[c] <= cnt_reg[c] + 3'h1;
			end
		end
	end
	assign o_chan_feedback = i_skip | (out_reg & ~i_dead);
endmodule // fps_regulators
`default_nettype wire

// [bench/fps_props.sv]
// port checker for the power sequencer
`timescale 1ns/100ps
`default_nettype none
module fps_props #(
	parameter int unsigned SEQ_DELAY_CYCLES   = 8,
	parameter int unsigned FAULT_PULSE_CYCLES = 16
) (
	input wire logic       i_sys_clk,
	input wire logic       i_rst,
	input wire logic       i_undervoltage_sense,
	input wire logic       i_fault_n_in,
	input wire logic [3:0] i_chan_feedback,
	input wire logic [3:0] o_chan_enable,
	input wire logic [3:0] o_offset_current_en,
	input wire logic       o_seq_done,
	input wire logic       o_power_good_out,
	input wire logic       o_fault_oe
);
	logic [7:0] run_reg;
	logic       uvl_reg;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	// length of the present drive on the fault line
	always_ff @(posedge i_sys_clk) begin
		if (o_fault_oe)
			run_reg <= run_reg + 8'h01;
		else
			run_reg <= 8'h00;
	end
	// remembers any undervoltage since reset
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			uvl_reg <= 1'b0;
		else if (!i_undervoltage_sense)
			uvl_reg <= 1'b1;
	end
	a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> o_chan_enable == 4'h0
		&& !o_seq_done && !o_power_good_out && !o_fault_oe) else $error("reset outputs");
	a_pok_waits: assert property ($rose(o_seq_done) && o_chan_enable != 4'h0
		|-> !o_power_good_out [*8]) else $error("power ok early");
	a_fault_drops: assert property ($rose(o_fault_oe)
		|-> ##[0:1] (o_chan_enable == 4'h0 && !o_seq_done)) else $error("fault kept outputs");
	a_pulse_width: assert property ($fell(o_fault_oe) && !uvl_reg
		|-> run_reg == 8'(FAULT_PULSE_CYCLES)) else $error("fault pulse width");
	a_ext_drop: assert property (!i_fault_n_in && !o_fault_oe && !$past(o_fault_oe, 3)
		|-> ##[1:4] o_chan_enable == 4'h0) else $error("outside fault ignored");
	a_done_all_good: assert property ($rose(o_seq_done)
		|-> i_chan_feedback == 4'hf) else $error("done without feedback");
	a_enable_spacing: assert property (|(o_chan_enable & ~$past(o_chan_enable))
		|-> $past(o_chan_enable, SEQ_DELAY_CYCLES) == $past(o_chan_enable)) else $error("step delay");
	a_offset_on_drop: assert property (o_seq_done && |($past(o_chan_enable) & ~o_chan_enable)
		|-> o_offset_current_en == ($past(o_chan_enable) & ~o_chan_enable)) else $error("offset");
endmodule // fps_props
`default_nettype wire

// [bench/tb_four_channel_power_sequencer.sv]
// testbench for the four-channel power sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_four_channel_power_sequencer;
	logic       clk, rst, pon, poff, uv, pull, done, power_good_out, oe;
	logic [3:0] skip, dead, fb, en, ofs;
	logic [2:0] lag;
	logic [5:0] q[$];
	logic [5:0] last;
	int         fail_count, n_checks, seed;
	wire logic  line = !(oe | pull);
	fps_sequencer #(.SEQ_DELAY_CYCLES(8), .PG_WINDOW_CYCLES(10), .RESET_TMO_CYCLES(12),
		.FAULT_PULSE_CYCLES(16)) DUT (.i_sys_clk(clk), .i_rst(rst), .i_power_on_cmp(pon),
		.i_power_off_cmp(poff), .i_chan_feedback(fb), .i_undervoltage_sense(uv),
		.i_fault_n_in(line), .o_chan_enable(en), .o_offset_current_en(ofs), .o_seq_done(done),
		.o_power_good_out(power_good_out), .o_fault_n_out(), .o_fault_oe(oe));
	fps_regulators u_reg (.i_sys_clk(clk), .i_chan_enable(en), .i_offset_current_en(ofs),
		.i_skip(skip), .i_dead(dead), .i_lag(lag), .o_chan_feedback(fb));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic note(input logic [3:0] e, input logic [1:0] f);
		q.push_back({e, f});
	endtask
	task automatic exp_on(input logic [3:0] m);
		logic [3:0] e;
		e = 4'h0;
		for (int c = 0; c < 4; c++) if (m[c]) begin
			e[c] = 1'b1;
			note(e, 2'b00);
		end
		note(e, 2'b10);
		note(e, 2'b11);
	endtask
	task automatic exp_off(input logic [3:0] m);
		logic [3:0] e;
		e = m;
		note(e, 2'b10);
		for (int c = 3; c >= 0; c--) if (m[c]) begin
			e[c] = 1'b0;
			note(e, 2'b10);
		end
		note(4'h0, 2'b00);
	endtask
	// fresh power-on edge with a random regulator lag
	task automatic start_on();
		pon <= 1'b0;
		tick(4);
		lag <= 3'(($random(seed) & 3) + 1);
		pon <= 1'b1;
	endtask
	task automatic wait_en();
		for (int i = 0; i < 100 && en[0] !== 1'b1; i++) tick(1);
	endtask
	task automatic settle(input string m);
		for (int i = 0; i < 400 && q.size() != 0; i++) tick(1);
		tick(40);
		chk(q.size() == 0, m);
		q.delete();
		$display("test done: %s", m);
	endtask
	task automatic stop_test();
		$display("checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// each output change is matched against the oldest note
	always @(posedge clk) begin
		if (rst) begin
			last = 6'h00;
		end else if ({en, done, power_good_out} !== last) begin
			last = {en, done, power_good_out};
			if (q.size() == 0) chk(1'b0, "unexpected change");
			else chk(q.pop_front() === last, "output step");
		end
	end
	// main sequence of scenarios
	initial begin
		seed = 32'h6d975cc8;
		{rst, pon, poff, uv, pull, skip, dead, lag} = {4'b1011, 1'b0, 8'h00, 3'h1};
		fail_count = 0;
		n_checks = 0;
		tick(12);
		rst <= 1'b0;
		tick(10);
		exp_on(4'hf); // full power-on
		start_on();
		settle("power on");
		exp_off(4'hf); // reverse power-off
		poff <= 1'b0;
		settle("power off");
		poff <= 1'b1; // rise is ignored
		pon <= 1'b0;
		settle("ignored edges");
		dead <= 4'h4;
		note(4'h1, 2'b00);
		note(4'h3, 2'b00);
		note(4'h7, 2'b00);
		note(4'h0, 2'b00); // window expiry
		start_on();
		settle("window expiry");
		dead <= 4'h0;
		note(4'h1, 2'b00);
		note(4'h0, 2'b00);
		start_on();
		wait_en();
		pull <= 1'b1; // outside pull drops all
		// hold the pull until the supplies have decayed, or init would skip them
		tick(16);
		chk(oe === 1'b0, "own drive on outside fault"); // no pulse
		pull <= 1'b0;
		settle("outside fault");
		skip <= 4'h2;
		note(4'h1, 2'b00);
		note(4'h0, 2'b00);
		start_on();
		wait_en();
		pon <= 1'b0; // power-on lost
		settle("power-on lost");
		exp_on(4'hd); // skipped channel
		start_on();
		settle("skipped channel");
		// enables, done and power-OK all fall on one edge
		note(4'h0, 2'b00); // undervoltage drop
		uv <= 1'b0;
		tick(40);
		chk(oe === 1'b1, "line held in undervoltage");
		uv <= 1'b1;
		settle("undervoltage");
		skip <= 4'hf;
		exp_on(4'h0); // all skipped: done, then power-OK
		pull <= 1'b1;
		tick(6);
		pull <= 1'b0;
		settle("all skipped");
		stop_test();
	end
	// whole run needs under a thousand cycles; the limit is 20000 cycles
	initial begin
		#100000;
		fail_count++;
		stop_test();
	end
endmodule // tb_four_channel_power_sequencer
bind fps_sequencer fps_props #(.SEQ_DELAY_CYCLES(SEQ_DELAY_CYCLES),
	.FAULT_PULSE_CYCLES(FAULT_PULSE_CYCLES)) u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_undervoltage_sense(i_undervoltage_sense), .i_fault_n_in(i_fault_n_in),
	.i_chan_feedback(i_chan_feedback), .o_chan_enable(o_chan_enable),
	.o_offset_current_en(o_offset_current_en), .o_seq_done(o_seq_done),
	.o_power_good_out(o_power_good_out), .o_fault_oe(o_fault_oe));
`default_nettype wire
